// file: rtl/parallel_io_port_64.sv
// General purpose 64-bit parallel input and output port with memory-mapped registers.
`timescale 1ns/1ps
module parallel_io_port_64
  import gpio_pkg::*;
#(
  parameter bit implement = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register bus
  input wire logic [addr_width-1:0] bus_addr,
  input wire logic bus_rden,
  input wire logic bus_wren,
  input wire logic [lane_count-1:0] bus_ben,
  input wire logic [half_width-1:0] bus_wdata,
  output logic [half_width-1:0] bus_rdata,
  output logic bus_ack,
  output logic bus_err,
  output logic device_err,
  // Parallel lines
  input wire logic [port_width-1:0] gpio_in,
  output logic [port_width-1:0] gpio_out
);
  // Internal reset: asserted with the pin, released two edges after it.
  logic [1:0] rst_pipe;
  logic [1:0] next_rst_pipe;
  logic rst_n;

  // Access decoded in the current cycle.
  reg_sel_t sel;
  logic [port_width/half_width-1:0] half_wr;
  logic wr_hit_out;
  logic wr_hit_in;
  logic rd_hit;

  // Output line storage.
  logic [port_width-1:0] out_reg;
  logic [port_width-1:0] next_out_reg;

  // Bus answer.
  logic [half_width-1:0] next_rdata;
  logic next_ack;
  logic next_err;

  sync_if lines ();

  // Maps a byte address onto the register that it selects.
  function automatic reg_sel_t decode(input logic [addr_width-1:0] addr);
    unique case (addr)
      addr_input_low: decode = sel_input_low;
      addr_input_high: decode = sel_input_high;
      addr_output_low: decode = sel_output_low;
      addr_output_high: decode = sel_output_high;
      default: decode = sel_none;
    endcase
  endfunction

  // True for either register of the read-only input side.
  function automatic logic is_input(input reg_sel_t s);
    is_input = (s == sel_input_low) || (s == sel_input_high);
  endfunction

  // Byte lanes whose enable is clear keep their old value.
  function automatic logic [half_width-1:0] merge_lanes(
    input logic [half_width-1:0] old_word,
    input logic [half_width-1:0] new_word,
    input logic [lane_count-1:0] enables
  );
    logic [half_width-1:0] merged;
    merged = old_word;
    for (int b = 0; b < lane_count; b++) begin
      if (enables[b]) begin
        merged[b*lane_width +: lane_width] = new_word[b*lane_width +: lane_width];
      end
    end
    merge_lanes = merged;
  endfunction

  // Value that a read of the selected register returns.
  function automatic logic [half_width-1:0] read_word(
    input reg_sel_t s,
    input logic [port_width-1:0] in_lines,
    input logic [port_width-1:0] out_lines
  );
    unique case (s)
      sel_input_low: read_word = in_lines[half_width-1:0];
      sel_input_high: read_word = in_lines[port_width-1:half_width];
      sel_output_low: read_word = out_lines[half_width-1:0];
      sel_output_high: read_word = out_lines[port_width-1:half_width];
      default: read_word = word_zero;
    endcase
  endfunction

  // Only the second stage feeds the reset net, so a slow rise of the pin cannot race the registers.
  always_comb begin
    next_rst_pipe = {rst_pipe[0], 1'b1};
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_pipe <= rst_sync_zero;
    end else begin
      rst_pipe <= next_rst_pipe;
    end
  end

  assign rst_n = rst_pipe[1];

  assign lines.raw = gpio_in;

  // The far-side lines are asynchronous, so they are filtered before software can see them.
  input_sync u_input_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .lines(lines.filt)
  );

  assign sel = decode(bus_addr);

  // A write wins over a read in the same cycle; a unit that is left out takes nothing at all.
  always_comb begin
    wr_hit_in = 1'b0;
    half_wr = '0;
    rd_hit = 1'b0;
    if (implement) begin
      if (bus_wren) begin
        wr_hit_in = is_input(sel);
        half_wr[0] = (sel == sel_output_low);
        half_wr[1] = (sel == sel_output_high);
      end else if (bus_rden) begin
        rd_hit = (sel != sel_none);
      end
    end
    wr_hit_out = |half_wr;
  end

  // Each half is its own register, so a 64-bit update always takes two accesses.
  genvar h;
  generate
    for (h = 0; h < port_width / half_width; h++) begin : g_half
      always_comb begin
        if (!implement) begin
          next_out_reg[h*half_width +: half_width] = word_zero;
        end else if (half_wr[h]) begin
          next_out_reg[h*half_width +: half_width] =
            merge_lanes(out_reg[h*half_width +: half_width], bus_wdata, bus_ben);
        end else begin
          next_out_reg[h*half_width +: half_width] = out_reg[h*half_width +: half_width];
        end
      end
    end
  endgenerate

  // A reset clears the lines, so loads on the far side see a known level from the start.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= port_zero;
    end else begin
      out_reg <= next_out_reg;
    end
  end

  // Read data is zero outside a read answer, so the bus can be OR-combined with other units.
  always_comb begin
    next_rdata = word_zero;
    if (rd_hit) begin
      next_rdata = read_word(sel, lines.stable, out_reg);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_rdata <= word_zero;
    end else begin
      bus_rdata <= next_rdata;
    end
  end

  always_comb begin
    next_ack = 1'b0;
    if (wr_hit_out || rd_hit) begin
      next_ack = 1'b1;
    end
  end

  // Unmapped addresses get no answer so that the system bus fault monitor can time them out.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= next_ack;
    end
  end

  always_comb begin
    next_err = 1'b0;
    if (wr_hit_in) begin
      next_err = 1'b1;
    end
  end

  // A refused store raises the bus error and the target device error cause together.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bus_err <= 1'b0;
      device_err <= 1'b0;
    end else begin
      bus_err <= next_err;
      device_err <= next_err;
    end
  end

  assign gpio_out = out_reg;
endmodule

// file: rtl/gpio_pkg.sv
// Constants shared by the parallel port design files.
package gpio_pkg;
  localparam int unsigned port_width = 64;
  localparam int unsigned half_width = 32;
  localparam int unsigned addr_width = 32;
  localparam int unsigned lane_count = 4;
  localparam int unsigned lane_width = 8;
  localparam logic [31:0] addr_input_low = 32'h0fffffc0;
  localparam logic [31:0] addr_input_high = 32'hffffffc4;
  localparam logic [31:0] addr_output_low = 32'h0fffffc8;
  localparam logic [31:0] addr_output_high = 32'hffffffcc;
  localparam logic [31:0] word_zero = 32'h00000000;
  localparam logic [63:0] port_zero = 64'h0000000000000000;
  localparam logic [1:0] rst_sync_zero = 2'h0;
  localparam logic [1:0] rst_sync_one = 2'h3;

  typedef enum logic [3:0] {
    sel_none = 4'h0,
    sel_input_low = 4'h1,
    sel_input_high = 4'h2,
    sel_output_low = 4'h4,
    sel_output_high = 4'h8
  } reg_sel_t;
endpackage

// file: rtl/sync_if.sv
// Carrier between the port top and its input synchroniser.
`timescale 1ns/1ps
interface sync_if;
  logic [63:0] raw;
  logic [63:0] stable;
  modport filt (input raw, output stable);
  modport user (output raw, input stable);
endinterface

// file: rtl/input_sync.sv
// Three-stage input synchroniser with agreement filter for the parallel input lines.
`timescale 1ns/1ps
module input_sync
  import gpio_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Lines
  sync_if.filt lines
);
  logic [port_width-1:0] stage1;
  logic [port_width-1:0] stage2;
  logic [port_width-1:0] stage3;
  logic [port_width-1:0] held;
  logic [port_width-1:0] next_held;

  // A bit is only accepted once two later stages agree, which hides one-cycle glitches.
  genvar i;
  generate
    for (i = 0; i < port_width; i++) begin : g_bit
      always_comb begin
        next_held[i] = (stage2[i] == stage3[i]) ? stage3[i] : held[i];
      end
    end
  endgenerate

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stage1 <= port_zero;
      stage2 <= port_zero;
      stage3 <= port_zero;
      held <= port_zero;
    end else begin
      stage1 <= lines.raw;
      stage2 <= stage1;
      stage3 <= stage2;
      held <= next_held;
    end
  end

  assign lines.stable = held;
endmodule

// file: bench/pin_model.sv
// Far-side pins that drive the port's input lines.
`timescale 1ns/1ps
module pin_model (
  // Lines
  input wire logic [63:0] level,
  output logic [63:0] lines
);
  assign lines = level;
endmodule

// file: bench/port_checker.sv
// Concurrent checks on the parallel port's bus and lines.
`timescale 1ns/1ps
module port_checker #(
  parameter bit implement = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Register bus
  input wire logic [31:0] bus_addr,
  input wire logic bus_rden,
  input wire logic bus_wren,
  input wire logic [3:0] bus_ben,
  input wire logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ack,
  input wire logic bus_err,
  input wire logic device_err,
  // Lines
  input wire logic [63:0] gpio_in,
  input wire logic [63:0] gpio_out
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  wire in_wr = implement && bus_wren && (bus_addr == 32'h0fffffc0 || bus_addr == 32'hffffffc4);
  wire lo_wr = implement && bus_wren && bus_ben == 4'hf && bus_addr == 32'h0fffffc8;
  wire rd = implement && bus_rden && !bus_wren;
  sequence quiet_in; $stable(gpio_in)[*4]; endsequence
  sequence rd_in_low; rd && bus_addr == 32'h0fffffc0; endsequence
  a_err_cause: assert property (bus_err == device_err) else $error("cause apart");
  a_input_refused: assert property (in_wr |=> bus_err && !bus_ack) else $error("input write");
  a_low_write: assert property (lo_wr |=> bus_ack && gpio_out[31:0] == $past(bus_wdata)) else $error("low");
  a_high_kept: assert property (lo_wr |=> $stable(gpio_out[63:32])) else $error("high moved");
  a_out_hold: assert property (!bus_wren |=> $stable(gpio_out)) else $error("drift");
  a_read_back: assert property (rd && bus_addr == 32'hffffffcc |=> bus_ack && bus_rdata == gpio_out[63:32])
    else $error("read back");
  a_input_read: assert property (quiet_in ##0 rd_in_low |=> bus_rdata == $past(gpio_in[31:0])) else $error("in");
  a_off_quiet: assert property (!implement |-> gpio_out == 64'h0 && !bus_ack && !bus_err && !device_err)
    else $error("left out unit active");
  a_read_ok: assert property (rd |=> !bus_err) else $error("read refused");
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the 64-bit parallel port.
`timescale 1ns/1ps
module tb_top;
  import gpio_pkg::*;
  logic mclk = 1'h0, arst_n = 1'h0, bus_rden = 1'h0, bus_wren = 1'h0, bus_ack, bus_err, device_err;
  logic [31:0] bus_addr = 32'h0, bus_wdata = 32'h0, bus_rdata;
  logic [3:0] bus_ben = 4'h0;
  logic [63:0] pins = 64'h0, gpio_in, gpio_out;
  int num_errors = 0, tests_run = 0, cycles = 0;
  parallel_io_port_64 DUT (.mclk, .arst_n, .bus_addr, .bus_rden, .bus_wren, .bus_ben, .bus_wdata, .bus_rdata,
    .bus_ack, .bus_err, .device_err, .gpio_in, .gpio_out);
  logic [31:0] off_rdata;
  logic off_ack, off_err, off_dev;
  logic [63:0] off_out;
  parallel_io_port_64 #(.implement(1'b0)) off_unit (.mclk, .arst_n, .bus_addr, .bus_rden, .bus_wren, .bus_ben,
    .bus_wdata, .bus_rdata(off_rdata), .bus_ack(off_ack), .bus_err(off_err), .device_err(off_dev), .gpio_in,
    .gpio_out(off_out));
  pin_model far (.level(pins), .lines(gpio_in));
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task chk(input string n, input logic [63:0] e, input logic [63:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  // Answer r is {err, cause, ack}; for reads d is the expected data.
  task acc(input logic w, input logic [31:0] a, input logic [3:0] b, input logic [31:0] d, input logic [2:0] r);
    @(negedge mclk);
    bus_wren = w;
    bus_rden = !w;
    bus_addr = a;
    bus_ben = b;
    bus_wdata = d;
    @(negedge mclk);
    bus_wren = 1'h0;
    bus_rden = 1'h0;
    chk("answer", 64'({bus_err, device_err, bus_ack}), 64'(r));
    chk("off answer", 64'({off_err, off_dev, off_ack, off_rdata}), 64'h0);
    if (!w) chk("data", 64'(d), 64'(bus_rdata));
  endtask
  initial begin
    repeat (5) @(negedge mclk);
    arst_n = 1'h1;
    repeat (3) @(negedge mclk);
    chk("reset", 64'h0, gpio_out);
    acc(1'h1, addr_output_low, 4'hf, 32'hdeadbeef, 3'h1);
    chk("low", 64'hdeadbeef, gpio_out);
    acc(1'h1, addr_output_high, 4'h5, 32'h12345678, 3'h1);
    chk("both", 64'h00340078deadbeef, gpio_out);
    chk("off lines", 64'h0, off_out);
    acc(1'h0, addr_output_high, 4'h0, 32'h00340078, 3'h1);
    pins = 64'hcafef00da5a5a5a5;
    repeat (4) @(negedge mclk);
    acc(1'h0, addr_input_low, 4'h0, 32'ha5a5a5a5, 3'h1);
    acc(1'h0, addr_input_high, 4'h0, 32'hcafef00d, 3'h1);
    acc(1'h1, addr_input_low, 4'hf, 32'h0, 3'h6);
    acc(1'h1, addr_input_high, 4'hf, 32'h0, 3'h6);
    acc(1'h1, 32'h0fffffd0, 4'hf, 32'h0, 3'h0);
    chk("kept", 64'h00340078deadbeef, gpio_out);
    arst_n = 1'h0;
    @(negedge mclk);
    chk("cleared", 64'h0, gpio_out);
    arst_n = 1'h1;
    repeat (3) @(negedge mclk);
    acc(1'h1, addr_output_low, 4'h3, 32'h00005a5a, 3'h1);
    chk("after reset", 64'h0000000000005a5a, gpio_out);
    wrap_up();
  end
endmodule
bind parallel_io_port_64 port_checker #(.implement(implement)) chk_i (.mclk, .arst_n, .bus_addr, .bus_rden,
  .bus_wren, .bus_ben,
  .bus_wdata, .bus_rdata, .bus_ack, .bus_err, .device_err, .gpio_in, .gpio_out);
